// File: demod_frontend_defines.svh
// Offsets, field positions, reset values and widths of the front-end config group.
// Included by the package, the register block, the host model and the bench; definitions only.
`ifndef DEMOD_FRONTEND_DEFINES_SVH
`define DEMOD_FRONTEND_DEFINES_SVH

`define ADDR_IO_PIN_FILTER_CONFIG 8'h0c
`define ADDR_GAIN_LOOP1_CONTROL 8'h0d
`define ADDR_TIMING_LOOP_COEFFICIENTS 8'h0e
`define ADDR_GAIN_LOOP1_REFERENCE 8'h0f
`define ADDR_GAIN_LOOP2_CONTROL 8'h10

`define RST_IO_PIN_FILTER_CONFIG 8'hf0
`define RST_GAIN_LOOP1_CONTROL 8'h81
`define RST_TIMING_LOOP_COEFFICIENTS 8'h23
`define RST_GAIN_LOOP1_REFERENCE 8'h54
`define RST_GAIN_LOOP2_CONTROL 8'h74

// io_pin_filter_config fields
`define BIT_OUT1_OPEN_DRAIN 7
`define BIT_OUT1_LEVEL 6
`define BIT_OUT0_OPEN_DRAIN 5
`define BIT_OUT0_LEVEL 4
`define MSB_FILTER_ROLLOFF 2
`define LSB_FILTER_ROLLOFF 1
`define BIT_Q_INVERT 0
// gain_loop1_control fields
`define BIT_DC_OFFSET_COMP 7
`define MSB_GAIN_LOOP1_COEFF 2
// timing_loop_coefficients fields
`define MSB_TIMING_ALPHA 6
`define LSB_TIMING_ALPHA 4
`define MSB_TIMING_BETA 2
// gain_loop1_reference fields
`define BIT_GAIN_POLARITY 7
`define MSB_GAIN_LOOP1_TARGET 5
// gain_loop2_control fields
`define MSB_GAIN_LOOP2_COEFF 7
`define LSB_GAIN_LOOP2_COEFF 5
`define MSB_GAIN_LOOP2_TARGET 4

`define SAMPLE_WIDTH 8
`define GAIN_WIDTH 8

`endif

// File: demod_frontend_pkg.sv
// Types shared by the front-end configuration block.
// Assumes demod_frontend_defines.svh is on the include path.
`include "demod_frontend_defines.svh"

package demod_frontend_pkg;

   typedef enum logic [1:0] {
      ROLLOFF_35 = 2'b00,
      ROLLOFF_20 = 2'b01,
      ROLLOFF_RES2 = 2'b10,
      ROLLOFF_RES3 = 2'b11
   } rolloff_t;

   typedef struct packed {
      logic dc_offset_comp_on;
      logic [2:0] gain_loop1_coefficient;
      logic [5:0] gain_loop1_target;
      logic [2:0] timing_alpha;
      logic [2:0] timing_beta;
      logic [2:0] gain_loop2_coefficient;
      logic [4:0] gain_loop2_target;
      rolloff_t filter_rolloff;
   } frontend_cfg_t;

   typedef struct packed {
      logic valid;
      logic signed [`SAMPLE_WIDTH-1:0] i;
      logic signed [`SAMPLE_WIDTH-1:0] q;
   } iq_sample_t;

endpackage

// File: output_pin_drive.sv
// One general output pin: push-pull or open-drain drive of a level.
// Assumes the pad merges out and oe; oe high means the pin is driven.
module output_pin_drive (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic open_drain_in,
   input wire logic level_in,
   output logic pin_out,
   output logic pin_oe_out
);

   logic next_pin;
   logic next_pin_oe;

   always_comb begin
      if (open_drain_in) begin
         // Open drain only pulls low; a high level releases the pin
         next_pin = 1'b0;
         next_pin_oe = ~level_in;
      end else begin
         next_pin = level_in;
         next_pin_oe = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         pin_out <= 1'b0;
         pin_oe_out <= 1'b0;
      end else begin
         pin_out <= next_pin;
         pin_oe_out <= next_pin_oe;
      end
   end

endmodule

// File: demod_frontend_config_regs.sv
// Front-end configuration registers of the demodulator and the small
// datapath they steer: general output pins, quadrature inversion after the
// derotator and gain-control polarity.
// Assumes the host control bus logic presents byte writes and reads on the
// device clock; samples and gain value come from logic on the same clock.
// Function
// - With the inversion bit 0 set, each quadrature sample is negated, except the most negative code, which saturates to the largest positive.
// - The negation sits after the derotator, which sees unaltered samples.
// - Bits [2:1] pick the filter roll-off, 00 for 35 percent and 01 for 20 percent.
// - With polarity bit 7 of the gain reference set, the gain output is complemented.
// - With that bit set, a larger gain output means lower tuner gain.
`include "demod_frontend_defines.svh"

module demod_frontend_config_regs (
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic wr_en_in,
   input wire logic rd_en_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   output logic [7:0] rdata_out,
   input wire demod_frontend_pkg::iq_sample_t derot_sample_in,
   output demod_frontend_pkg::iq_sample_t filter_sample_out,
   input wire logic [`GAIN_WIDTH-1:0] gain_value_in,
   output logic [`GAIN_WIDTH-1:0] gain_ctrl_out,
   output demod_frontend_pkg::frontend_cfg_t cfg_out,
   output logic general_output_one_out,
   output logic general_output_one_oe_out,
   output logic general_output_zero_out,
   output logic general_output_zero_oe_out
);

   logic [7:0] io_pin_filter_config;
   logic [7:0] gain_loop1_control;
   logic [7:0] timing_loop_coefficients;
   logic [7:0] gain_loop1_reference;
   logic [7:0] gain_loop2_control;
   logic [7:0] next_io_pin_filter_config;
   logic [7:0] next_gain_loop1_control;
   logic [7:0] next_timing_loop_coefficients;
   logic [7:0] next_gain_loop1_reference;
   logic [7:0] next_gain_loop2_control;
   logic [7:0] next_rdata;

   // Register writes and read mux
   always_comb begin
      next_io_pin_filter_config = io_pin_filter_config;
      next_gain_loop1_control = gain_loop1_control;
      next_timing_loop_coefficients = timing_loop_coefficients;
      next_gain_loop1_reference = gain_loop1_reference;
      next_gain_loop2_control = gain_loop2_control;
      // Reserved bits are stored as written; the host keeps them at zero
      if (wr_en_in) begin
         unique case (addr_in)
            `ADDR_IO_PIN_FILTER_CONFIG: next_io_pin_filter_config = wdata_in;
            `ADDR_GAIN_LOOP1_CONTROL: next_gain_loop1_control = wdata_in;
            `ADDR_TIMING_LOOP_COEFFICIENTS: next_timing_loop_coefficients = wdata_in;
            `ADDR_GAIN_LOOP1_REFERENCE: next_gain_loop1_reference = wdata_in;
            `ADDR_GAIN_LOOP2_CONTROL: next_gain_loop2_control = wdata_in;
            default: ;
         endcase
      end
      next_rdata = rdata_out;
      if (rd_en_in) begin
         unique case (addr_in)
            `ADDR_IO_PIN_FILTER_CONFIG: next_rdata = io_pin_filter_config;
            `ADDR_GAIN_LOOP1_CONTROL: next_rdata = gain_loop1_control;
            `ADDR_TIMING_LOOP_COEFFICIENTS: next_rdata = timing_loop_coefficients;
            `ADDR_GAIN_LOOP1_REFERENCE: next_rdata = gain_loop1_reference;
            `ADDR_GAIN_LOOP2_CONTROL: next_rdata = gain_loop2_control;
            // Outside this group reads as zero
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         io_pin_filter_config <= `RST_IO_PIN_FILTER_CONFIG;
         gain_loop1_control <= `RST_GAIN_LOOP1_CONTROL;
         timing_loop_coefficients <= `RST_TIMING_LOOP_COEFFICIENTS;
         gain_loop1_reference <= `RST_GAIN_LOOP1_REFERENCE;
         gain_loop2_control <= `RST_GAIN_LOOP2_CONTROL;
         rdata_out <= 8'h00;
      end else begin
         io_pin_filter_config <= next_io_pin_filter_config;
         gain_loop1_control <= next_gain_loop1_control;
         timing_loop_coefficients <= next_timing_loop_coefficients;
         gain_loop1_reference <= next_gain_loop1_reference;
         gain_loop2_control <= next_gain_loop2_control;
         rdata_out <= next_rdata;
      end
   end

   // Field decode; every field comes straight from a flip-flop
   always_comb begin
      cfg_out.dc_offset_comp_on = gain_loop1_control[`BIT_DC_OFFSET_COMP];
      cfg_out.gain_loop1_coefficient = gain_loop1_control[`MSB_GAIN_LOOP1_COEFF:0];
      cfg_out.gain_loop1_target = gain_loop1_reference[`MSB_GAIN_LOOP1_TARGET:0];
      cfg_out.timing_alpha =
         timing_loop_coefficients[`MSB_TIMING_ALPHA:`LSB_TIMING_ALPHA];
      cfg_out.timing_beta = timing_loop_coefficients[`MSB_TIMING_BETA:0];
      cfg_out.gain_loop2_coefficient =
         gain_loop2_control[`MSB_GAIN_LOOP2_COEFF:`LSB_GAIN_LOOP2_COEFF];
      cfg_out.gain_loop2_target = gain_loop2_control[`MSB_GAIN_LOOP2_TARGET:0];
      // Reserved codes pass through unchanged; filter treats them as undefined
      cfg_out.filter_rolloff = demod_frontend_pkg::rolloff_t'(
         io_pin_filter_config[`MSB_FILTER_ROLLOFF:`LSB_FILTER_ROLLOFF]);
   end

   output_pin_drive u_out_one (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .open_drain_in(io_pin_filter_config[`BIT_OUT1_OPEN_DRAIN]),
      .level_in(io_pin_filter_config[`BIT_OUT1_LEVEL]),
      .pin_out(general_output_one_out),
      .pin_oe_out(general_output_one_oe_out)
   );

   output_pin_drive u_out_zero (
      .clk_sys_in(clk_sys_in),
      .rst_in(rst_in),
      .open_drain_in(io_pin_filter_config[`BIT_OUT0_OPEN_DRAIN]),
      .level_in(io_pin_filter_config[`BIT_OUT0_LEVEL]),
      .pin_out(general_output_zero_out),
      .pin_oe_out(general_output_zero_oe_out)
   );

   // Sample path and gain polarity, one cycle of latency each
   demod_frontend_pkg::iq_sample_t next_filter_sample;
   logic [`GAIN_WIDTH-1:0] next_gain_ctrl;
   logic q_invert;
   logic gain_invert;

   assign q_invert = io_pin_filter_config[`BIT_Q_INVERT];
   assign gain_invert = gain_loop1_reference[`BIT_GAIN_POLARITY];

   always_comb begin
      next_filter_sample = derot_sample_in;
      // Input already derotated, so the derotator never sees the flip
      if (q_invert) begin
         // Most negative code saturates instead of wrapping onto itself
         if (derot_sample_in.q == {1'b1, {(`SAMPLE_WIDTH-1){1'b0}}}) begin
            next_filter_sample.q = {1'b0, {(`SAMPLE_WIDTH-1){1'b1}}};
         end else begin
            next_filter_sample.q = -derot_sample_in.q;
         end
      end
      // Complement turns a rising loop value into a falling one
      next_gain_ctrl = gain_invert ? ~gain_value_in : gain_value_in;
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         filter_sample_out <= '0;
         gain_ctrl_out <= '0;
      end else begin
         filter_sample_out <= next_filter_sample;
         gain_ctrl_out <= next_gain_ctrl;
      end
   end

   // Checks
   sequence s_write_ctl;
      wr_en_in && addr_in == `ADDR_GAIN_LOOP1_CONTROL;
   endsequence

   sequence s_read_ctl;
      rd_en_in && !wr_en_in && addr_in == `ADDR_GAIN_LOOP1_CONTROL;
   endsequence

   a_q_inverted: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (q_invert && derot_sample_in.q != {1'b1, {(`SAMPLE_WIDTH-1){1'b0}}})
      |=> filter_sample_out.q == -$past(derot_sample_in.q))
      else $error("Quadrature sample not negated");

   a_q_after_derot: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !q_invert |=> filter_sample_out == $past(derot_sample_in))
      else $error("Sample altered with inversion off");

   a_rolloff_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (wr_en_in && addr_in == `ADDR_IO_PIN_FILTER_CONFIG)
      |=> cfg_out.filter_rolloff == $past(wdata_in[2:1]))
      else $error("Roll-off field does not follow write");

   a_gain_polarity: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      1'b1 |=> gain_ctrl_out == ($past(gain_invert) ? ~$past(gain_value_in)
                                                    : $past(gain_value_in)))
      else $error("Gain output polarity wrong");

   a_gain_sense: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (gain_invert && $past(gain_invert) && gain_value_in > $past(gain_value_in))
      |=> gain_ctrl_out < $past(gain_ctrl_out))
      else $error("Inverted gain output not falling");

   a_reset_values: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $past(rst_in) |-> io_pin_filter_config == `RST_IO_PIN_FILTER_CONFIG
         && gain_loop1_control == `RST_GAIN_LOOP1_CONTROL
         && timing_loop_coefficients == `RST_TIMING_LOOP_COEFFICIENTS
         && gain_loop1_reference == `RST_GAIN_LOOP1_REFERENCE
         && gain_loop2_control == `RST_GAIN_LOOP2_CONTROL)
      else $error("Register reset value wrong");

   // Host leaves one idle cycle after each write before its next request
   a_read_back: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      s_write_ctl ##1 !wr_en_in ##1 s_read_ctl |=> rdata_out == $past(wdata_in, 3))
      else $error("Read-back differs from last write");

   a_unmapped_read: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (rd_en_in && (addr_in < `ADDR_IO_PIN_FILTER_CONFIG || addr_in > `ADDR_GAIN_LOOP2_CONTROL))
      |=> rdata_out == 8'h00)
      else $error("Unmapped read not zero");

   // Read data must stand until the next read strobe
   a_rdata_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !rd_en_in |=> $stable(rdata_out))
      else $error("Read data changed without a read");

   a_q_saturate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      (q_invert && derot_sample_in.q == {1'b1, {(`SAMPLE_WIDTH-1){1'b0}}})
      |=> filter_sample_out.q == {1'b0, {(`SAMPLE_WIDTH-1){1'b1}}})
      else $error("Most negative quadrature code not saturated");

endmodule

// File: host_bus_model.sv
// Host controller model: drives the byte-wide strobe bus of the config group.
// Assumes the bench calls its tasks at a falling edge of clk_sys_in.
`include "demod_frontend_defines.svh"

module host_bus_model (
   input wire logic clk_sys_in,
   input wire logic [7:0] rdata_in,
   output logic wr_en_out,
   output logic rd_en_out,
   output logic [7:0] addr_out,
   output logic [7:0] wdata_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // Writable bits per address; reserved fields always go out as zero
   function automatic logic [7:0] legal_mask(input logic [7:0] addr);
      case (addr)
         `ADDR_IO_PIN_FILTER_CONFIG: legal_mask = 8'hf7;
         `ADDR_GAIN_LOOP1_CONTROL: legal_mask = 8'h87;
         `ADDR_TIMING_LOOP_COEFFICIENTS: legal_mask = 8'h77;
         `ADDR_GAIN_LOOP1_REFERENCE: legal_mask = 8'hbf;
         default: legal_mask = 8'hff;
      endcase
   endfunction

   initial begin
      wr_en_out = 1'b0;
      rd_en_out = 1'b0;
      addr_out = 8'h00;
      wdata_out = 8'h00;
   end

   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      addr_out = addr;
      wdata_out = data & legal_mask(addr);
      wr_en_out = 1'b1;
      @(negedge clk_sys_in);
      wr_en_out = 1'b0;
      // Released data lines must not look like a held value
      wdata_out = ~wdata_out;
      // Idle edge, so a second write never re-raises the strobe in the same step
      @(negedge clk_sys_in);
   endtask

   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      addr_out = addr;
      rd_en_out = 1'b1;
      @(negedge clk_sys_in);
      rd_en_out = 1'b0;
      @(negedge clk_sys_in);
      data = rdata_in;
   endtask
endmodule

// File: tb_demod_frontend_config_regs.sv
// Self-checking bench for the front-end config registers and their datapath.
// Assumes the design files and host_bus_model are compiled before it.
`include "demod_frontend_defines.svh"

module tb_demod_frontend_config_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_in = 1'b0;
   logic rst_in = 1'b1;
   logic wr_en, rd_en, one, one_oe, zero, zero_oe;
   logic [7:0] addr, wdata, rdata, rd, gain_ctrl;
   logic [7:0] gain_value = 8'h00;
   demod_frontend_pkg::iq_sample_t derot_sample = '0;
   demod_frontend_pkg::iq_sample_t filter_sample;
   demod_frontend_pkg::frontend_cfg_t cfg;
   int miscompares = 0;
   int check_count = 0;
   logic [7:0] addrs [5] = '{`ADDR_IO_PIN_FILTER_CONFIG, `ADDR_GAIN_LOOP1_CONTROL,
      `ADDR_TIMING_LOOP_COEFFICIENTS, `ADDR_GAIN_LOOP1_REFERENCE, `ADDR_GAIN_LOOP2_CONTROL};
   logic [7:0] rsts [5] = '{`RST_IO_PIN_FILTER_CONFIG, `RST_GAIN_LOOP1_CONTROL,
      `RST_TIMING_LOOP_COEFFICIENTS, `RST_GAIN_LOOP1_REFERENCE, `RST_GAIN_LOOP2_CONTROL};
   logic [7:0] pats [5] = '{8'ha2, 8'h05, 8'h52, 8'h2a, 8'h8b};
   logic [7:0] pins [4] = '{8'h40, 8'hf2, 8'ha0, 8'h12};

   always #10 clk_sys_in = ~clk_sys_in;

   host_bus_model HOST (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .wr_en_out(wr_en),
      .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata));

   demod_frontend_config_regs DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
      .wr_en_in(wr_en), .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata),
      .rdata_out(rdata), .derot_sample_in(derot_sample), .filter_sample_out(filter_sample),
      .gain_value_in(gain_value), .gain_ctrl_out(gain_ctrl), .cfg_out(cfg),
      .general_output_one_out(one), .general_output_one_oe_out(one_oe),
      .general_output_zero_out(zero), .general_output_zero_oe_out(zero_oe));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Drives one sample and gain value, checks them a cycle later
   task automatic step(input logic [7:0] q, input logic [7:0] g, input logic [7:0] eq,
         input logic [7:0] eg);
      derot_sample = '{valid: 1'b1, i: 8'h21, q: q};
      gain_value = g;
      @(negedge clk_sys_in);
      check(32'(filter_sample), {15'h0, 1'b1, 8'h21, eq});
      check(32'(gain_ctrl), 32'(eg));
   endtask

   initial begin
      repeat (2) @(posedge clk_sys_in);
      @(negedge clk_sys_in);
      rst_in = 1'b0;
      for (int k = 0; k < 5; k++) begin
         HOST.read_reg(addrs[k], rd);
         check(32'(rd), 32'(rsts[k]));
      end
      for (int k = 0; k < 5; k++) begin
         HOST.write_reg(addrs[k], pats[k]);
         HOST.read_reg(addrs[k], rd);
         check(32'(rd), 32'(pats[k]));
      end
      check(32'(cfg), 32'({1'b0, 3'h5, 6'h2a, 3'h5, 3'h2, 3'h4, 5'h0b, 2'h1}));
      HOST.read_reg(8'h0b, rd);
      check(32'(rd), 32'h0);
      // Pin drive: open drain leaves the pin driven only while pulling low
      for (int k = 0; k < 4; k++) begin
         HOST.write_reg(`ADDR_IO_PIN_FILTER_CONFIG, pins[k]);
         @(negedge clk_sys_in);
         check(32'(cfg.filter_rolloff), 32'(pins[k][2:1]));
         check({one, one_oe}, {pins[k][7] ? 1'b0 : pins[k][6], ~(pins[k][7] & pins[k][6])});
         check({zero, zero_oe}, {pins[k][5] ? 1'b0 : pins[k][4], ~(pins[k][5] & pins[k][4])});
      end
      HOST.write_reg(`ADDR_IO_PIN_FILTER_CONFIG, 8'h01);
      step(8'h05, 8'h10, 8'hfb, 8'h10);
      step(8'h80, 8'h3c, 8'h7f, 8'h3c);
      step(8'h7f, 8'h00, 8'h81, 8'h00);
      HOST.write_reg(`ADDR_GAIN_LOOP1_REFERENCE, 8'h80);
      step(8'h05, 8'h10, 8'hfb, 8'hef);
      step(8'h00, 8'h00, 8'h00, 8'hff);
      HOST.write_reg(`ADDR_IO_PIN_FILTER_CONFIG, 8'h00);
      step(8'h05, 8'hf0, 8'h05, 8'h0f);
      step(8'h80, 8'h01, 8'h80, 8'hfe);
      // Reset in mid-run must restore every register and idle the outputs
      rst_in = 1'b1;
      @(negedge clk_sys_in);
      check({one, one_oe, zero, zero_oe}, 32'h0);
      check(32'(gain_ctrl), 32'h0);
      rst_in = 1'b0;
      for (int k = 0; k < 5; k++) begin
         HOST.read_reg(addrs[k], rd);
         check(32'(rd), 32'(rsts[k]));
      end
      final_report();
   end

   initial begin
      #50us;
      miscompares++;
      final_report();
   end
endmodule
